// ===== design/dcf_pkg.sv
// shared constants and types for the 9-bit synchronous fifo
package dcf_pkg;
    // data path width
    localparam int DCF_DATA_W = 9;
    // documented default depth
    localparam int DCF_DEPTH_DEF = 64;
    // each offset register is one byte wide
    localparam int DCF_OFS_W = 8;
    // an offset is formed from a low and a high byte
    localparam int DCF_OFS_SUM_W = 16;
    // offset defaults: empty and full offsets both seven words
    localparam logic [7:0] DCF_OFS_LO_RST = 8'h07;
    localparam logic [7:0] DCF_OFS_HI_RST = 8'h00;
    // mode captured during reset
    localparam logic DCF_MODE_PROG = 1'b0;
    localparam logic DCF_MODE_TWO_EN = 1'b1;

    // offset register selector, walked by successive offset writes
    typedef enum logic [3:0] {
        DCF_SEL_EMPTY_LO = 4'h1,
        DCF_SEL_EMPTY_HI = 4'h2,
        DCF_SEL_FULL_LO = 4'h4,
        DCF_SEL_FULL_HI = 4'h8
    } dcf_sel_t;
endpackage

// ===== design/dcf_buffer.sv
// parameterised storage fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dcf_buffer #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16,
    parameter int LVL_W = $clog2(DEPTH + 1),
    parameter int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [LVL_W-1:0] level
);
    localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [LVL_W-1:0] level_q;
    logic push;
    logic pop;

    // handshakes; ready drops when full so the source stalls
    assign in_ready = (level_q != FULL_LVL);
    assign out_valid = (level_q != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_q[rd_ptr_q];
    assign level = level_q;

    // storage array, no reset needed on the contents
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // write pointer, wraps for any depth not only powers of two
    always_ff @(posedge clk)
    begin
        if (rst)
            wr_ptr_q <= '0;
        else if (push)
            wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
    end

    // read pointer
    always_ff @(posedge clk)
    begin
        if (rst)
            rd_ptr_q <= '0;
        else if (pop)
            rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
    end

    // fill level, push and pop together leave it unchanged
    always_ff @(posedge clk)
    begin
        if (rst)
            level_q <= '0;
        else if (push && !pop)
            level_q <= level_q + 1'b1;
        else if (pop && !push)
            level_q <= level_q - 1'b1;
    end
endmodule // dcf_buffer
`default_nettype wire

// ===== design/dcf_fifo_top.sv
// 9-bit synchronous fifo with programmable almost-empty/almost-full flags
// Contract
// - prog mode: enable a low, not full writes
// - two-enable mode: a low, b high, not full
// - back-to-back writes, one word per cycle
// - dual pin level during reset selects mode
// - writes ignored while full flag low
// - read advances when both enables low, nonempty
// - load strobe writes selected offset register
// - load strobe read shows selected offset register
// - empty flag low exactly when no words
// - full flag low exactly when all locations used
// - almost-empty low when count at or below n
// - almost-full low when free at or below m
// - reset empties fifo and asserts empty flags
// - output enable low drives data bus
// - read and write share one clock
// - data in and out nine bits
// - depth parameter from 64 to 8K
// - both offsets default to seven words
// - offset writes cycle four registers, resume
// - empty fifo keeps last read word
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_top
    import dcf_pkg::*;
#(
    parameter int DEPTH = DCF_DEPTH_DEF,
    parameter int LVL_W = $clog2(DEPTH + 1)
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [DCF_DATA_W-1:0] din,
    input wire logic wr_en_a_n,
    input wire logic wr_en_b_or_load,
    input wire logic rd_en_a_n,
    input wire logic rd_en_b_n,
    input wire logic oe_n,
    output logic [DCF_DATA_W-1:0] dout,
    output logic dout_oe,
    output logic empty_n,
    output logic full_n,
    output logic almost_empty_n,
    output logic almost_full_n
);
    localparam logic [DCF_OFS_SUM_W-1:0] DEPTH_W = DCF_OFS_SUM_W'(DEPTH);

    logic mode_q;
    logic offset_load_n;
    logic load_active;
    logic wr_req;
    logic rd_req;
    logic push;
    logic pop;
    logic ofs_wr;
    logic ofs_rd;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [DCF_DATA_W-1:0] buf_out_data;
    logic [LVL_W-1:0] level;
    logic [DCF_OFS_SUM_W-1:0] lvl_nxt;
    logic [DCF_OFS_SUM_W-1:0] free_nxt;
    logic [DCF_OFS_SUM_W-1:0] empty_ofs;
    logic [DCF_OFS_SUM_W-1:0] full_ofs;
    logic [DCF_OFS_W-1:0] ofs_q [4];
    logic [DCF_OFS_W-1:0] ofs_sel_val;
    dcf_sel_t sel_q;
    logic [DCF_DATA_W-1:0] dout_q;
    logic dout_oe_q;
    logic empty_n_q;
    logic full_n_q;
    logic almost_empty_n_q;
    logic almost_full_n_q;

    // map a selector state onto its offset register slot
    function automatic logic [1:0] sel_index(input dcf_sel_t s);
        unique case (s)
            DCF_SEL_EMPTY_LO: sel_index = 2'h0;
            DCF_SEL_EMPTY_HI: sel_index = 2'h1;
            DCF_SEL_FULL_LO: sel_index = 2'h2;
            DCF_SEL_FULL_HI: sel_index = 2'h3;
            default: sel_index = 2'h0;
        endcase
    endfunction

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            mode_q <= wr_en_b_or_load;
    end

    // the dual pin acts as active-low load strobe only in prog mode
    assign offset_load_n = wr_en_b_or_load;
    assign load_active = (mode_q == DCF_MODE_PROG) && !offset_load_n;

    // second enable may come from expansion logic
    assign wr_req = !rst && !wr_en_a_n &&
        ((mode_q == DCF_MODE_TWO_EN) ? wr_en_b_or_load : !load_active);

    // one push per cycle while enabled
    assign push = wr_req && full_n_q && buf_in_ready;

    assign rd_req = !rst && !rd_en_a_n && !rd_en_b_n;
    assign pop = rd_req && !load_active && empty_n_q && buf_out_valid;

    assign ofs_wr = !rst && load_active && !wr_en_a_n;
    assign ofs_rd = rd_req && load_active;

    // nine-bit storage with back-pressure from the full side
    dcf_buffer #(
        .WIDTH(DCF_DATA_W),
        .DEPTH(DEPTH),
        .LVL_W(LVL_W)
    ) u_buf (
        .clk(ref_clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data(din),
        .out_valid(buf_out_valid),
        .out_ready(pop),
        .out_data(buf_out_data),
        .level(level)
    );

    // shared clock, so flags come straight from next level
    // simultaneous push and pop in one cycle
    assign lvl_nxt = DCF_OFS_SUM_W'(level) + DCF_OFS_SUM_W'(push) - DCF_OFS_SUM_W'(pop);
    assign free_nxt = DEPTH_W - lvl_nxt;
    assign empty_ofs = {ofs_q[1], ofs_q[0]};
    assign full_ofs = {ofs_q[3], ofs_q[2]};
    assign ofs_sel_val = ofs_q[sel_index(sel_q)];

    // offset selector walks four registers, wraps
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            sel_q <= DCF_SEL_EMPTY_LO;
        else if (ofs_wr)
        begin
            unique case (sel_q)
                DCF_SEL_EMPTY_LO: sel_q <= DCF_SEL_EMPTY_HI;
                DCF_SEL_EMPTY_HI: sel_q <= DCF_SEL_FULL_LO;
                DCF_SEL_FULL_LO: sel_q <= DCF_SEL_FULL_HI;
                DCF_SEL_FULL_HI: sel_q <= DCF_SEL_EMPTY_LO;
                default: sel_q <= DCF_SEL_EMPTY_LO;
            endcase
        end
    end

    // offset register load from din low byte
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ofs_q[0] <= DCF_OFS_LO_RST;
            ofs_q[1] <= DCF_OFS_HI_RST;
            ofs_q[2] <= DCF_OFS_LO_RST;
            ofs_q[3] <= DCF_OFS_HI_RST;
        end
        else if (ofs_wr)
            ofs_q[sel_index(sel_q)] <= din[DCF_OFS_W-1:0];
    end

    // output register holds last word when nothing is read
    // offset contents on read with load low
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            dout_q <= '0;
        else if (ofs_rd)
            dout_q <= {1'b0, ofs_sel_val};
        else if (pop)
            dout_q <= buf_out_data;
    end

    // bus drive follows output enable, one cycle late
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            dout_oe_q <= 1'b0;
        else
            dout_oe_q <= !oe_n;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            empty_n_q <= 1'b0;
        else
            empty_n_q <= (lvl_nxt != '0);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            full_n_q <= 1'b1;
        else
            full_n_q <= (lvl_nxt != DEPTH_W);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            almost_empty_n_q <= 1'b0;
        else
            almost_empty_n_q <= (lvl_nxt > empty_ofs);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            almost_full_n_q <= 1'b1;
        else
            almost_full_n_q <= (free_nxt > full_ofs);
    end

    // outputs straight from flops
    assign dout = dout_q;
    assign dout_oe = dout_oe_q;
    assign empty_n = empty_n_q;
    assign full_n = full_n_q;
    assign almost_empty_n = almost_empty_n_q;
    assign almost_full_n = almost_full_n_q;

    AST_PROG_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
        (mode_q == DCF_MODE_PROG) && !wr_en_a_n && offset_load_n && full_n && !pop
        |=> level == $past(level) + 1'b1)
        else $error("prog-mode write did not store a word");

    AST_TWO_EN_GATE: assert property (@(posedge ref_clk) disable iff (rst)
        (mode_q == DCF_MODE_TWO_EN) && !wr_en_b_or_load
        |=> level <= $past(level))
        else $error("write taken with second enable low");

    AST_FULL_BLOCKS_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
        !full_n && !pop |=> $stable(level))
        else $error("level changed while full");

    AST_EMPTY_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
        empty_n == (level != '0))
        else $error("empty flag disagrees with level");

    AST_FULL_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
        full_n == (DCF_OFS_SUM_W'(level) != DEPTH_W))
        else $error("full flag disagrees with level");

    // almost-empty against the offset when it did not just change
    AST_ALMOST_EMPTY: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(ofs_wr) |-> almost_empty_n == (DCF_OFS_SUM_W'(level) > empty_ofs))
        else $error("almost-empty flag wrong");

    AST_ALMOST_FULL: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(ofs_wr) |-> almost_full_n == ((DEPTH_W - DCF_OFS_SUM_W'(level)) > full_ofs))
        else $error("almost-full flag wrong");

    AST_RESET_EMPTY: assert property (@(posedge ref_clk)
        rst |=> !empty_n && !almost_empty_n && full_n && level == '0)
        else $error("reset did not empty the fifo");

    // reads on empty keep the output word
    AST_HOLD_EMPTY: assert property (@(posedge ref_clk) disable iff (rst)
        !empty_n && rd_req && !load_active |=> $stable(dout))
        else $error("output changed on an empty read");

    // selector wraps after the fourth register
    AST_OFS_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
        ofs_wr && sel_q == DCF_SEL_FULL_HI |=> sel_q == DCF_SEL_EMPTY_LO)
        else $error("offset selector did not wrap");

    AST_OE_FOLLOW: assert property (@(posedge ref_clk) disable iff (rst)
        !oe_n |=> dout_oe)
        else $error("data outputs not driven");

    // a legal read advances the output to the head word
    AST_READ_ADV: assert property (@(posedge ref_clk) disable iff (rst)
        pop |=> dout == $past(buf_out_data))
        else $error("read did not present head word");
endmodule // dcf_fifo_top
`default_nettype wire

// ===== tb/dcf_partner.sv
// producer and consumer model that drives the fifo's write and read pins
`timescale 1ns/1ps
`default_nettype none
module dcf_partner
    import dcf_pkg::*;
(
    input wire logic ref_clk,
    output var logic [DCF_DATA_W-1:0] din,
    output var logic wr_en_a_n,
    output var logic wr_en_b_or_load,
    output var logic rd_en_a_n,
    output var logic rd_en_b_n,
    output var logic oe_n
);
    // quiet pins from time zero
    // no access before reset
    initial
    begin
        din = '0;
        wr_en_a_n = 1'b1;
        wr_en_b_or_load = 1'b1;
        rd_en_a_n = 1'b1;
        rd_en_b_n = 1'b1;
        oe_n = 1'b1;
    end

    // one cycle of pin levels, changed just after the rising edge
    task automatic cyc(input logic wa, input logic wb, input logic ra, input logic rb,
                       input logic oe, input logic [DCF_DATA_W-1:0] d);
        @(posedge ref_clk);
        #1;
        wr_en_b_or_load = wb;
        wr_en_a_n = wa;
        rd_en_a_n = ra;
        rd_en_b_n = rb;
        oe_n = oe;
        // an idle bus flips so a stale word never looks fresh
        din = wa ? ~din : d;
    endtask
endmodule // dcf_partner
`default_nettype wire

// ===== tb/tb_dcf_fifo_top.sv
// self-checking bench for the 9-bit fifo with its pin-level partner
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("[FAIL] t=%0t got %h exp %h", $time, (got), (exp)); \
        end \
    end
module tb_dcf_fifo_top
    import dcf_pkg::*;
;
    localparam int DEPTH = 64;
    localparam int MAX_CYC = 2000;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [DCF_DATA_W-1:0] din;
    logic [DCF_DATA_W-1:0] dout;
    logic wr_en_a_n;
    logic wr_en_b_or_load;
    logic rd_en_a_n;
    logic rd_en_b_n;
    logic oe_n;
    logic dout_oe;
    logic empty_n;
    logic full_n;
    logic almost_empty_n;
    logic almost_full_n;
    int bad_count = 0;
    int check_count = 0;
    int cyc_n = 0;

    // 40 MHz clock
    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    dcf_fifo_top #(.DEPTH(DEPTH)) DUT (.ref_clk(ref_clk), .rst(rst), .din(din),
        .wr_en_a_n(wr_en_a_n), .wr_en_b_or_load(wr_en_b_or_load), .rd_en_a_n(rd_en_a_n),
        .rd_en_b_n(rd_en_b_n), .oe_n(oe_n), .dout(dout), .dout_oe(dout_oe),
        .empty_n(empty_n), .full_n(full_n), .almost_empty_n(almost_empty_n),
        .almost_full_n(almost_full_n));

    dcf_partner model (.ref_clk(ref_clk), .din(din), .wr_en_a_n(wr_en_a_n),
        .wr_en_b_or_load(wr_en_b_or_load), .rd_en_a_n(rd_en_a_n), .rd_en_b_n(rd_en_b_n),
        .oe_n(oe_n));

    // distinct words; an odd step keeps all 64 apart
    function automatic logic [DCF_DATA_W-1:0] pat(input int i);
        pat = DCF_DATA_W'(i * 37 + 11);
    endfunction

    // pin high keeps an idle cycle out of offset access in either mode
    task automatic idle();
        model.cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '0);
    endtask

    task automatic chk_flags(input int lvl, input int n, input int m);
        `CHK(empty_n, 1'(lvl != 0))
        `CHK(full_n, 1'(lvl != DEPTH))
        `CHK(almost_empty_n, 1'(lvl > n))
        `CHK(almost_full_n, 1'((DEPTH - lvl) > m))
    endtask

    // back-to-back writes up to full, flags checked after every word
    task automatic fill(input int n, input int m);
        for (int i = 0; i <= DEPTH; i++)
        begin
            if (i < DEPTH)
                model.cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, pat(i));
            else
                idle();
            if (i > 0)
                chk_flags(i, n, m);
        end
    endtask

    // back-to-back reads down to empty, order and flags checked
    task automatic drain(input int n, input int m);
        for (int i = 0; i <= DEPTH; i++)
        begin
            if (i < DEPTH)
                model.cyc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, '0);
            else
                idle();
            if (i > 0)
            begin
                `CHK(dout, pat(i - 1))
                chk_flags(DEPTH - i, n, m);
            end
        end
    endtask

    // 20-cycle reset with the mode level on the dual pin
    task automatic do_reset(input logic md);
        model.cyc(1'b1, md, 1'b1, 1'b1, 1'b1, '0);
        rst = 1'b1;
        repeat (20) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        `CHK(dout, 9'h000)
        `CHK(dout_oe, 1'b0)
        chk_flags(0, 7, 7);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // hang guard; the whole run needs well under 600 cycles
    always @(posedge ref_clk)
    begin
        cyc_n++;
        if (cyc_n == MAX_CYC)
        begin
            bad_count++;
            $display("[FAIL] t=%0t timeout", $time);
            final_report();
        end
    end

    // main sequence: two-enable mode, then programmable-flag mode
    initial
    begin
        do_reset(DCF_MODE_TWO_EN);
        model.cyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 9'h155);
        idle();
        `CHK(empty_n, 1'b0)
        fill(7, 7);
        // full write dropped, single read enable ignored
        model.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 9'h1FF);
        idle();
        `CHK(dout, 9'h000)
        chk_flags(DEPTH, 7, 7);
        drain(7, 7);
        model.cyc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, '0);
        idle();
        `CHK(dout, pat(DEPTH - 1))
        // read and write in one cycle leave the level alone
        model.cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, pat(0));
        model.cyc(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, pat(1));
        idle();
        `CHK(dout, pat(0))
        chk_flags(1, 7, 7);
        model.cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, '0);
        idle();
        `CHK(dout_oe, 1'b1)
        idle();
        `CHK(dout_oe, 1'b0)
        $display("test two_enable done");
        do_reset(DCF_MODE_PROG);
        model.cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, '0);
        idle();
        `CHK(dout, 9'h007)
        // top data bit set: only the low byte may land
        model.cyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 9'h102);
        idle();
        model.cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, '0);
        idle();
        `CHK(dout, 9'h000)
        model.cyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 9'h000);
        model.cyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 9'h003);
        model.cyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 9'h000);
        idle();
        model.cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, '0);
        idle();
        `CHK(dout, 9'h002)
        `CHK(empty_n, 1'b0)
        fill(2, 3);
        drain(2, 3);
        $display("test programmable done");
        final_report();
    end
endmodule // tb_dcf_fifo_top
`default_nettype wire
